// ### io_wdt_pkg.sv
package io_wdt_pkg;

    // ------------------------------------------------------------------
    // port map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] PERIOD_KICK_PORT = 12'h0443;
    localparam logic [11:0] STOP_PORT_LO = 12'h0043;
    localparam logic [11:0] STOP_PORT_HI = 12'h0843;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 125_000_000;
    localparam int TICK_S = 1;
    localparam int TICK_CYCLES = CLK_HZ * TICK_S;
    localparam int PERIOD_W = 8;
    localparam logic [7:0] PERIOD_RESET = 8'h00;
    localparam logic [7:0] READ_DATA_IDLE = 8'hff;
    localparam int RESET_PULSE_CYCLES = 16;

    typedef enum logic [1:0] {
        WD_IDLE,
        WD_RUN,
        WD_FIRE
    } wd_state_t;

endpackage : io_wdt_pkg

// ### io_port_watchdog_timer.sv
`timescale 1ns/100ps
module io_port_watchdog_timer
    import io_wdt_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES,
    parameter int PULSE_LEN = RESET_PULSE_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // host i/o port access
    input wire logic [ADDR_W-1:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    // status and board reset
    output logic wd_enabled_o,
    output logic board_reset_o
);

    // ------------------------------------------------------------------
    // port decode
    // ------------------------------------------------------------------
    function automatic logic is_stop(input logic [ADDR_W-1:0] a);
        is_stop = (a == STOP_PORT_LO) || (a == STOP_PORT_HI);
    endfunction : is_stop

    logic wr_period;
    logic rd_kick;
    logic rd_stop;
    always_comb begin
        wr_period = 1'b0;
        rd_kick = 1'b0;
        rd_stop = 1'b0;
        if (io_addr_i == PERIOD_KICK_PORT) begin
            wr_period = io_wr_i;
            rd_kick = io_rd_i;
        end else if (is_stop(io_addr_i)) begin
            rd_stop = io_rd_i;
        end
    end

    // ------------------------------------------------------------------
    // watchdog state
    // ------------------------------------------------------------------
    wd_state_t state_q, state_d;
    logic [PERIOD_W-1:0] period_q, period_d;
    logic [PERIOD_W-1:0] secs_q, secs_d;
    logic [31:0] tick_q, tick_d;
    logic [31:0] pulse_q, pulse_d;
    logic [7:0] rdata_q, rdata_d;
    logic enabled_q, enabled_d;
    logic rst_out_q, rst_out_d;

    always_comb begin
        state_d = state_q;
        period_d = period_q;
        secs_d = secs_q;
        tick_d = tick_q;
        pulse_d = pulse_q;
        rdata_d = READ_DATA_IDLE;
        if (wr_period) begin
            period_d = io_wdata_i[PERIOD_W-1:0];
        end
        if (rd_kick) begin
            rdata_d = period_q;
        end
        case (state_q)
            WD_IDLE: begin
                if (rd_kick) begin
                    state_d = WD_RUN;
                    secs_d = period_q;
                    tick_d = 32'(TICK_LEN - 1);
                end
            end
            WD_RUN: begin
                if (rd_stop) begin
                    state_d = WD_IDLE;
                end else if (rd_kick) begin
                    secs_d = period_q;
                    tick_d = 32'(TICK_LEN - 1);
                end else if (tick_q != 32'h0000_0000) begin
                    tick_d = tick_q - 32'h0000_0001;
                end else if (secs_q <= 8'h01) begin
                    // zero period expires at the first tick, same as one second
                    state_d = WD_FIRE;
                    pulse_d = 32'(PULSE_LEN - 1);
                end else begin
                    secs_d = secs_q - 8'h01;
                    tick_d = 32'(TICK_LEN - 1);
                end
            end
            WD_FIRE: begin
                // the pulse runs to its end; the board is being rebooted anyway
                if (pulse_q != 32'h0000_0000) begin
                    pulse_d = pulse_q - 32'h0000_0001;
                end else begin
                    state_d = WD_IDLE;
                end
            end
            default: state_d = WD_IDLE;
        endcase
        enabled_d = (state_d == WD_RUN);
        rst_out_d = (state_d == WD_FIRE);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            state_q <= WD_IDLE;
            period_q <= PERIOD_RESET;
            secs_q <= 8'h00;
            tick_q <= 32'h0000_0000;
            pulse_q <= 32'h0000_0000;
            rdata_q <= READ_DATA_IDLE;
            enabled_q <= 1'b0;
            rst_out_q <= 1'b0;
        end else begin
            state_q <= state_d;
            period_q <= period_d;
            secs_q <= secs_d;
            tick_q <= tick_d;
            pulse_q <= pulse_d;
            rdata_q <= rdata_d;
            enabled_q <= enabled_d;
            rst_out_q <= rst_out_d;
        end
    end

    assign io_rdata_o = rdata_q;
    assign wd_enabled_o = enabled_q;
    assign board_reset_o = rst_out_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_write_loads_period: assert property (
        wr_period |=> period_q == $past(io_wdata_i))
        else $error("period write did not load");
    a_write_no_start: assert property (
        wr_period && !rd_kick && state_q == WD_IDLE |=> state_q == WD_IDLE)
        else $error("period write changed state");
    a_kick_enables: assert property (
        rd_kick && state_q == WD_IDLE |=> wd_enabled_o && secs_q == $past(period_q))
        else $error("kick read did not start countdown");
    a_stop_disables: assert property (
        rd_stop && state_q == WD_RUN |=> !wd_enabled_o ##1 !board_reset_o)
        else $error("stop read did not disable");
    a_tick_reload: assert property (
        state_q == WD_RUN && tick_q == 0 && secs_q > 1 && !rd_kick && !rd_stop
        |=> secs_q == $past(secs_q) - 8'h01 && tick_q == 32'(TICK_LEN - 1))
        else $error("second step wrong");
    a_expiry_fires: assert property (
        state_q == WD_RUN && tick_q == 0 && secs_q <= 1 && !rd_kick && !rd_stop
        |=> board_reset_o)
        else $error("expiry did not assert reset");
    a_kick_restarts: assert property (
        rd_kick && state_q == WD_RUN && !rd_stop
        |=> secs_q == $past(period_q) && tick_q == 32'(TICK_LEN - 1))
        else $error("kick did not restart period");
    a_reset_needs_run: assert property (
        $rose(board_reset_o) |-> $past(state_q) == WD_RUN)
        else $error("reset without running countdown");
    a_period_byte: assert property (
        wr_period |=> period_q == $past(io_wdata_i[7:0]))
        else $error("period not low data byte");

    a_kick_rdata: assert property (
        rd_kick |=> io_rdata_o == $past(period_q))
        else $error("kick read did not return the period");
    a_rdata_idle: assert property (
        !rd_kick |=> io_rdata_o == READ_DATA_IDLE)
        else $error("read data not idle outside a kick read");
    a_stop_idle_quiet: assert property (
        rd_stop && state_q == WD_IDLE |=> state_q == WD_IDLE && !wd_enabled_o)
        else $error("stop read while idle changed state");
    a_tick_countdown: assert property (
        state_q == WD_RUN && tick_q != 0 && !rd_kick && !rd_stop
        |=> wd_enabled_o && tick_q == $past(tick_q) - 32'h0000_0001)
        else $error("tick countdown wrong");
    a_fire_no_enable: assert property (
        state_q == WD_FIRE |=> !wd_enabled_o)
        else $error("watchdog enabled during reset pulse");

    // ------------------------------------------------------------------
    // reset pulse length
    // ------------------------------------------------------------------
    // counts the cycles the board reset has stood, checked as it falls
    logic [31:0] hi_cnt_q, hi_cnt_d;
    always_comb begin
        hi_cnt_d = 32'h0000_0000;
        if (rst_out_q) begin
            hi_cnt_d = hi_cnt_q + 32'h0000_0001;
        end
    end
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            hi_cnt_q <= 32'h0000_0000;
        end else begin
            hi_cnt_q <= hi_cnt_d;
        end
    end

    a_pulse_length: assert property (
        $fell(board_reset_o) |-> hi_cnt_q == 32'(PULSE_LEN))
        else $error("board reset pulse length wrong");

    c_start: cover property (rd_kick && state_q == WD_IDLE);
    c_restart: cover property (rd_kick && state_q == WD_RUN);
    c_stop: cover property (rd_stop && state_q == WD_RUN);
    c_fire: cover property ($rose(board_reset_o));
    c_period_write: cover property (wr_period && state_q == WD_IDLE);

endmodule : io_port_watchdog_timer

// ### io_host_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------------
// host processor issuing single-byte i/o port cycles
// ------------------------------------------------------------------
module io_host_model
    import io_wdt_pkg::*;
(
    // clock
    input wire logic clk_i,
    // i/o port access
    output logic [ADDR_W-1:0] io_addr_o,
    output logic io_wr_o,
    output logic io_rd_o,
    output logic [7:0] io_wdata_o,
    input wire logic [7:0] io_rdata_i
);
    initial begin
        io_addr_o = 12'h0000;
        io_wr_o = 1'b0;
        io_rd_o = 1'b0;
        io_wdata_o = 8'h00;
    end
    // released address and data lines show the inverse so a stale value is never mistaken for a live one
    task automatic access(input logic wr, input logic [11:0] addr, input logic [7:0] data,
                          output logic [7:0] rdata);
        @(posedge clk_i);
        io_addr_o <= addr;
        io_wdata_o <= data;
        io_wr_o <= wr;
        io_rd_o <= !wr;
        @(posedge clk_i);
        io_wr_o <= 1'b0;
        io_rd_o <= 1'b0;
        io_addr_o <= ~addr;
        io_wdata_o <= ~data;
        #1 rdata = io_rdata_i;
    endtask : access
    task automatic program_period(input logic [7:0] p);
        logic [7:0] unused;
        access(1'b1, PERIOD_KICK_PORT, p, unused);
    endtask : program_period
    task automatic kick(output logic [7:0] rdata);
        access(1'b0, PERIOD_KICK_PORT, 8'h00, rdata);
    endtask : kick
    task automatic stop(input logic [11:0] addr);
        logic [7:0] unused;
        access(1'b0, addr, 8'h00, unused);
    endtask : stop
endmodule : io_host_model

// ### tb_top.sv
`timescale 1ns/100ps
module tb_top import io_wdt_pkg::*;;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [ADDR_W-1:0] io_addr;
    logic io_wr;
    logic io_rd;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic wd_enabled;
    logic board_reset;
    logic [7:0] rd;
    int miscompares = 0;
    int cmp_count = 0;
    int fired = 0;
    always #4 clk_i = ~clk_i;
    // cycles with the board reset high, so silence and pulse length are both visible
    always @(posedge clk_i) if (board_reset === 1'b1) fired++;
    io_port_watchdog_timer #(.TICK_LEN(10), .PULSE_LEN(4)) io_port_watchdog_timer_inst (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .io_addr_i(io_addr), .io_wr_i(io_wr),
        .io_rd_i(io_rd), .io_wdata_i(io_wdata), .io_rdata_o(io_rdata),
        .wd_enabled_o(wd_enabled), .board_reset_o(board_reset));
    io_host_model io_host_model_inst (
        .clk_i(clk_i), .io_addr_o(io_addr), .io_wr_o(io_wr), .io_rd_o(io_rd),
        .io_wdata_o(io_wdata), .io_rdata_i(io_rdata));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", miscompares, cmp_count);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict
    task automatic t_start();
        @(posedge clk_i);
        #1 check("rdata idle", 16'(io_rdata), 16'h00ff);
        io_host_model_inst.program_period(8'h05);
        repeat (60) @(posedge clk_i);
        check("enabled after write", 16'(wd_enabled), 16'h0000);
        check("fired after write", 16'(fired), 16'h0000);
        io_host_model_inst.kick(rd);
        check("period read back", 16'(rd), 16'h0005);
        check("enabled after kick", 16'(wd_enabled), 16'h0001);
        @(posedge clk_i);
        #1 check("rdata after read", 16'(io_rdata), 16'h00ff);
    endtask : t_start
    task automatic t_refresh();
        repeat (4) begin
            repeat (45) @(posedge clk_i);
            io_host_model_inst.kick(rd);
        end
        check("fired while kicked", 16'(fired), 16'h0000);
        io_host_model_inst.stop(STOP_PORT_HI);
        check("enabled after stop hi", 16'(wd_enabled), 16'h0000);
        io_host_model_inst.kick(rd);
        io_host_model_inst.stop(STOP_PORT_LO);
        check("enabled after stop lo", 16'(wd_enabled), 16'h0000);
        repeat (80) @(posedge clk_i);
        check("fired after stop", 16'(fired), 16'h0000);
    endtask : t_refresh
    task automatic t_expire(input logic [7:0] p);
        int n;
        int f;
        n = 0;
        f = fired;
        io_host_model_inst.program_period(p);
        io_host_model_inst.kick(rd);
        while (board_reset !== 1'b1 && n < 3000) begin
            @(posedge clk_i);
            #1 n++;
        end
        check("expiry cycles", 16'(n), 16'(p) * 16'h000a);
        check("enabled at fire", 16'(wd_enabled), 16'h0000);
        repeat (10) @(posedge clk_i);
        check("pulse cycles", 16'(fired - f), 16'h0004);
    endtask : t_expire
    task automatic t_reset();
        int f;
        f = fired;
        io_host_model_inst.program_period(8'h02);
        io_host_model_inst.kick(rd);
        repeat (5) @(posedge clk_i);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        #1 check("enabled after reset", 16'(wd_enabled), 16'h0000);
        repeat (40) @(posedge clk_i);
        check("fired after reset", 16'(fired - f), 16'h0000);
        io_host_model_inst.kick(rd);
        check("period after reset", 16'(rd), 16'(PERIOD_RESET));
        io_host_model_inst.stop(STOP_PORT_LO);
        check("enabled after reset stop", 16'(wd_enabled), 16'h0000);
    endtask : t_reset
    initial begin
        repeat (16) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_start();
        t_refresh();
        t_expire(8'h01);
        t_expire(8'hff);
        t_reset();
        give_verdict();
    end
    // the whole run needs about 3000 cycles
    initial begin
        #80000;
        miscompares++;
        give_verdict();
    end
endmodule : tb_top
